// File: src/meccf_regs.vh
`ifndef MECCF_REGS_VH
`define MECCF_REGS_VH

// ----------------------------------------------------------------------------
// Register indices; the bus byte address is four times the index.
// ----------------------------------------------------------------------------
`define MECCF_IDX_PCFG 16'ha00d
`define MECCF_IDX_PADL 16'ha00e
`define MECCF_IDX_PADH 16'ha00f
`define MECCF_IDX_DCFG 16'ha02d
`define MECCF_IDX_DADL 16'ha02e
`define MECCF_IDX_DADH 16'ha02f
`define MECCF_IDX_RCTL 16'ha030

// ----------------------------------------------------------------------------
// Configuration register fields.
// ----------------------------------------------------------------------------
`define MECCF_B_EN 7
`define MECCF_B_UIE 5
`define MECCF_B_CIE 4
`define MECCF_B_UF 1
`define MECCF_B_CF 0
`define MECCF_B_RSTEN 0
`define MECCF_CFG_WMASK 8'hb0
`define MECCF_FLAG_MASK 8'h03
`define MECCF_PADH_RMASK 8'h3f

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define MECCF_CFG_RST 8'h80
`define MECCF_FADDR_RST 16'h8000

`endif

// File: src/meccf_byte_codec.v
`timescale 1ns/1ps

module meccf_byte_codec
(
  input wire [7:0] wrData,
  output wire [12:0] wrCode,
  input wire [12:0] rdCode,
  output reg [7:0] rdData,
  output wire rdCorr,
  output wire rdUncorr
);

  // --------------------------------------------------------------------------
  // Hamming check bits over positions 3,5,6,7,9,10,11,12.
  // --------------------------------------------------------------------------
  function [3:0] hamP;
    input [7:0] d;
    begin
      hamP = {d[4] ^ d[5] ^ d[6] ^ d[7],
              d[1] ^ d[2] ^ d[3] ^ d[7],
              d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6],
              d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6]};
    end
  endfunction

  wire [3:0] wrHam;
  wire [3:0] syn;
  wire par;
  reg [7:0] fix;

  assign wrHam = hamP(wrData);
  assign wrCode = {^{wrData, wrHam}, wrHam, wrData};
  assign syn = hamP(rdCode[7:0]) ^ rdCode[11:8];
  assign par = ^rdCode;
  // Syndromes above 12 point outside the word, so they cannot be single errors.
  assign rdCorr = par && (syn <= 4'hc);
  assign rdUncorr = (!par && (syn != 4'h0)) || (par && (syn > 4'hc));

  always @*
  begin
    fix = 8'h00;
    case (syn)
      4'h3: fix[0] = 1'b1;
      4'h5: fix[1] = 1'b1;
      4'h6: fix[2] = 1'b1;
      4'h7: fix[3] = 1'b1;
      4'h9: fix[4] = 1'b1;
      4'ha: fix[5] = 1'b1;
      4'hb: fix[6] = 1'b1;
      4'hc: fix[7] = 1'b1;
      default: fix = 8'h00;
    endcase
    rdData = rdCode[7:0] ^ (rdCorr ? fix : 8'h00);
  end

endmodule

// File: src/meccf_nib_codec.v
`timescale 1ns/1ps

module meccf_nib_codec
(
  input wire [7:0] code,
  output reg [3:0] data,
  output wire corr,
  output wire uncorr
);

  // --------------------------------------------------------------------------
  // Check nibble: bits 2..0 Hamming, bit 3 overall parity.
  // --------------------------------------------------------------------------
  wire [2:0] ham;
  wire [2:0] syn;
  wire par;
  reg [3:0] fix;

  assign ham = {code[1] ^ code[2] ^ code[3],
                code[0] ^ code[2] ^ code[3],
                code[0] ^ code[1] ^ code[3]};
  assign syn = ham ^ code[6:4];
  assign par = ^code;
  assign corr = par;
  assign uncorr = !par && (syn != 3'h0);

  always @*
  begin
    fix = 4'h0;
    case (syn)
      3'h3: fix[0] = 1'b1;
      3'h5: fix[1] = 1'b1;
      3'h6: fix[2] = 1'b1;
      3'h7: fix[3] = 1'b1;
      default: fix = 4'h0;
    endcase
    data = code[3:0] ^ (corr ? fix : 4'h0);
  end

endmodule

// File: src/meccf_top.v
`timescale 1ns/1ps
`include "meccf_regs.vh"

// Summary of operation
// - Data bytes stored with five check bits, 2048 x 13; encode on write, check on read.
// - Each data byte: single-bit errors corrected, double-bit errors detected.
// - Uncorrectable data error captures the address and raises an interrupt request.
// - Corrected data value returned to CPU; hardware does not rewrite memory.
// - Data config resets to 0x80: enable, two interrupt enables, two flags.
// - Data flags set on read errors while enable is set, regardless of interrupt enables, held until cleared.
// - Data interrupt enables gate the matching data error requests.
// - Data fault address holds the first error while its flag stays set.
// - Flash word: low byte instruction, high byte its check code.
// - Check bits 15:12 protect bits 7:4, bits 11:8 protect bits 3:0.
// - Each nibble independently corrects one bit and detects two.
// - Fetch checking is concurrent; corrected byte delivered, optional interrupt.
// - Uncorrectable fetch error raises interrupt or requests reset per configuration.
// - Any fetch error latches the fetch address into program fault address.
// - Program fault address holds the most recent fetch error; a PADH write replaces its high byte unless a fetch error lands in the same cycle.
// - Program fault address bits 15:14 always read zero.
// - Uncorrectable program flag set regardless of enable, held until cleared.
// - Correctable program flag set regardless of enable, held until cleared.
// - Program config resets to 0x80, flash-controller read correction on.
// - Program interrupt enables gate the matching program error requests.
// - Reset-enable bit, default zero, makes uncorrectable fetch errors request reset.
// - Correction off: flash-controller reads return raw flash contents.
module meccf_top
(
  input wire clk_sys,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  input wire protWriteUnlock,
  input wire cpuDataRd,
  input wire cpuDataWr,
  input wire [15:0] cpuDataAddr,
  input wire [7:0] cpuDataWdata,
  output wire [7:0] cpuDataRdata,
  output wire cpuDataRvalid,
  output wire [10:0] sramAddr,
  output wire sramRd,
  output wire sramWr,
  output wire [12:0] sramWdata,
  input wire [12:0] sramRdata,
  input wire fetchReq,
  input wire [15:0] fetchAddr,
  output wire [7:0] fetchData,
  output wire fetchValid,
  input wire fcReadReq,
  input wire [15:0] fcReadAddr,
  output wire fcReadReady,
  output wire [15:0] fcReadData,
  output wire fcReadValid,
  output wire fcReadFail,
  output wire [15:0] flashAddr,
  output wire flashRd,
  input wire [15:0] flashRdata,
  output wire dataUncorrIrq,
  output wire dataCorrIrq,
  output wire progUncorrIrq,
  output wire progCorrIrq,
  output wire fetchErrReset
);

  // --------------------------------------------------------------------------
  // Register select codes.
  // --------------------------------------------------------------------------
  localparam SEL_NONE = 3'd0;
  localparam SEL_PCFG = 3'd1;
  localparam SEL_PADL = 3'd2;
  localparam SEL_PADH = 3'd3;
  localparam SEL_DCFG = 3'd4;
  localparam SEL_DADL = 3'd5;
  localparam SEL_DADH = 3'd6;
  localparam SEL_RCTL = 3'd7;

  function [2:0] regSel;
    input [31:0] a;
    begin
      if ((a[1:0] != 2'b00) || (a[31:18] != 14'h0000))
        regSel = SEL_NONE;
      else
      begin
        case (a[17:2])
          `MECCF_IDX_PCFG: regSel = SEL_PCFG;
          `MECCF_IDX_PADL: regSel = SEL_PADL;
          `MECCF_IDX_PADH: regSel = SEL_PADH;
          `MECCF_IDX_DCFG: regSel = SEL_DCFG;
          `MECCF_IDX_DADL: regSel = SEL_DADL;
          `MECCF_IDX_DADH: regSel = SEL_DADH;
          `MECCF_IDX_RCTL: regSel = SEL_RCTL;
          default: regSel = SEL_NONE;
        endcase
      end
    end
  endfunction

  // Flags keep a 1 written back, drop on a written 0, and hardware sets win.
  function [7:0] cfgNext;
    input [7:0] cfg;
    input [7:0] wdata;
    input wen;
    input uEv;
    input cEv;
    reg [7:0] base;
    begin
      base = cfg;
      if (wen)
        base = (wdata & `MECCF_CFG_WMASK) | (cfg & wdata & `MECCF_FLAG_MASK);
      cfgNext = base;
      cfgNext[`MECCF_B_UF] = base[`MECCF_B_UF] | uEv;
      cfgNext[`MECCF_B_CF] = base[`MECCF_B_CF] | cEv;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Bus slave.
  // --------------------------------------------------------------------------
  reg wrPendReg;
  reg [2:0] wrSelReg;
  reg rdPendReg;
  reg [2:0] rdSelReg;
  reg [31:0] hrdataReg;
  reg [7:0] rdMux;
  wire accept;
  wire wrCommit;

  reg [7:0] progCfgReg;
  reg [7:0] progCfgNext;
  reg [15:0] progFaultAddrReg;
  reg [7:0] dataCfgReg;
  reg [7:0] dataCfgNext;
  reg [15:0] dataFaultAddrReg;
  reg fetchErrResetEnReg;

  // Reads take one wait state so a write just before them is always seen.
  assign accept = hsel && htrans[1] && hready;
  assign wrCommit = wrPendReg;
  assign hreadyout = !rdPendReg;
  assign hrdata = hrdataReg;
  assign hresp = 1'b0;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPendReg <= 1'b0;
      wrSelReg <= SEL_NONE;
      rdPendReg <= 1'b0;
      rdSelReg <= SEL_NONE;
      hrdataReg <= 32'h0000_0000;
    end
    else
    begin
      wrPendReg <= accept && hwrite;
      rdPendReg <= accept && !hwrite;
      if (accept)
      begin
        wrSelReg <= regSel(haddr);
        rdSelReg <= regSel(haddr);
      end
      if (rdPendReg)
        hrdataReg <= {24'h00_0000, rdMux};
    end
  end

  always @*
  begin
    case (rdSelReg)
      SEL_PCFG: rdMux = progCfgReg;
      SEL_PADL: rdMux = progFaultAddrReg[7:0];
      SEL_PADH: rdMux = progFaultAddrReg[15:8] & `MECCF_PADH_RMASK;
      SEL_DCFG: rdMux = dataCfgReg;
      SEL_DADL: rdMux = dataFaultAddrReg[7:0];
      SEL_DADH: rdMux = dataFaultAddrReg[15:8];
      SEL_RCTL: rdMux = {7'h00, fetchErrResetEnReg};
      default: rdMux = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Data memory path.
  // --------------------------------------------------------------------------
  reg [10:0] sramAddrReg;
  reg sramRdReg;
  reg sramWrReg;
  reg [12:0] sramWdataReg;
  reg [15:0] dAddr1Reg;
  reg [15:0] dAddr2Reg;
  reg dRd2Reg;
  reg [7:0] cpuDataRdataReg;
  reg cpuDataRvalidReg;
  wire [12:0] dEncoded;
  wire [7:0] dCorrected;
  wire dCorr;
  wire dUncorr;
  wire dataEn;
  wire dCorrEv;
  wire dUncorrEv;

  assign dataEn = dataCfgReg[`MECCF_B_EN];
  assign sramAddr = sramAddrReg;
  assign sramRd = sramRdReg;
  assign sramWr = sramWrReg;
  assign sramWdata = sramWdataReg;
  assign cpuDataRdata = cpuDataRdataReg;
  assign cpuDataRvalid = cpuDataRvalidReg;

  meccf_byte_codec u_byte
  (
    .wrData(cpuDataWdata),
    .wrCode(dEncoded),
    .rdCode(sramRdata),
    .rdData(dCorrected),
    .rdCorr(dCorr),
    .rdUncorr(dUncorr)
  );

  assign dCorrEv = dRd2Reg && dataEn && dCorr;
  assign dUncorrEv = dRd2Reg && dataEn && dUncorr;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sramAddrReg <= 11'h000;
      sramRdReg <= 1'b0;
      sramWrReg <= 1'b0;
      sramWdataReg <= 13'h0000;
      dAddr1Reg <= 16'h0000;
      dAddr2Reg <= 16'h0000;
      dRd2Reg <= 1'b0;
      cpuDataRdataReg <= 8'h00;
      cpuDataRvalidReg <= 1'b0;
    end
    else
    begin
      // A write takes priority when both strobes arrive together.
      sramWrReg <= cpuDataWr;
      sramRdReg <= cpuDataRd && !cpuDataWr;
      if (cpuDataWr || cpuDataRd)
      begin
        sramAddrReg <= cpuDataAddr[10:0];
        dAddr1Reg <= cpuDataAddr;
      end
      if (cpuDataWr)
        sramWdataReg <= dataEn ? dEncoded : {5'h00, cpuDataWdata};
      dRd2Reg <= sramRdReg;
      dAddr2Reg <= dAddr1Reg;
      cpuDataRvalidReg <= dRd2Reg;
      if (dRd2Reg)
        cpuDataRdataReg <= dataEn ? dCorrected : sramRdata[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // Program flash path.
  // --------------------------------------------------------------------------
  reg [15:0] flashAddrReg;
  reg flashRdReg;
  reg fSrcFetch1Reg;
  reg fSrcFetch2Reg;
  reg [15:0] fAddr1Reg;
  reg [15:0] fAddr2Reg;
  reg fValid2Reg;
  reg [7:0] fetchDataReg;
  reg fetchValidReg;
  reg [15:0] fcReadDataReg;
  reg fcReadValidReg;
  reg fcReadFailReg;
  reg fetchErrResetReg;
  wire [3:0] pLoNib;
  wire [3:0] pHiNib;
  wire pLoCorr;
  wire pLoUncorr;
  wire pHiCorr;
  wire pHiUncorr;
  wire pUncorr;
  wire pCorr;
  wire pCorrEv;
  wire pUncorrEv;
  wire pFetchErr;

  assign flashAddr = flashAddrReg;
  assign flashRd = flashRdReg;
  assign fetchData = fetchDataReg;
  assign fetchValid = fetchValidReg;
  assign fcReadReady = !fetchReq;
  assign fcReadData = fcReadDataReg;
  assign fcReadValid = fcReadValidReg;
  assign fcReadFail = fcReadFailReg;
  assign fetchErrReset = fetchErrResetReg;

  meccf_nib_codec u_nib_lo
  (
    .code({flashRdata[11:8], flashRdata[3:0]}),
    .data(pLoNib),
    .corr(pLoCorr),
    .uncorr(pLoUncorr)
  );

  meccf_nib_codec u_nib_hi
  (
    .code({flashRdata[15:12], flashRdata[7:4]}),
    .data(pHiNib),
    .corr(pHiCorr),
    .uncorr(pHiUncorr)
  );

  // One nibble may be corrected while the other fails; the byte then fails.
  assign pUncorr = pLoUncorr || pHiUncorr;
  assign pCorr = (pLoCorr || pHiCorr) && !pUncorr;
  assign pCorrEv = fValid2Reg && pCorr;
  assign pUncorrEv = fValid2Reg && pUncorr;
  assign pFetchErr = fValid2Reg && fSrcFetch2Reg && (pCorr || pUncorr);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flashAddrReg <= 16'h0000;
      flashRdReg <= 1'b0;
      fSrcFetch1Reg <= 1'b0;
      fSrcFetch2Reg <= 1'b0;
      fAddr1Reg <= 16'h0000;
      fAddr2Reg <= 16'h0000;
      fValid2Reg <= 1'b0;
      fetchDataReg <= 8'h00;
      fetchValidReg <= 1'b0;
      fcReadDataReg <= 16'h0000;
      fcReadValidReg <= 1'b0;
      fcReadFailReg <= 1'b0;
      fetchErrResetReg <= 1'b0;
    end
    else
    begin
      // Fetches always win the flash port; the controller waits on fcReadReady.
      flashRdReg <= fetchReq || fcReadReq;
      if (fetchReq || fcReadReq)
      begin
        flashAddrReg <= fetchReq ? fetchAddr : fcReadAddr;
        fAddr1Reg <= fetchReq ? fetchAddr : fcReadAddr;
        fSrcFetch1Reg <= fetchReq;
      end
      fValid2Reg <= flashRdReg;
      fSrcFetch2Reg <= fSrcFetch1Reg;
      fAddr2Reg <= fAddr1Reg;
      fetchValidReg <= fValid2Reg && fSrcFetch2Reg;
      fcReadValidReg <= fValid2Reg && !fSrcFetch2Reg;
      if (fValid2Reg && fSrcFetch2Reg)
        fetchDataReg <= {pHiNib, pLoNib};
      if (fValid2Reg && !fSrcFetch2Reg)
      begin
        if (progCfgReg[`MECCF_B_EN])
          fcReadDataReg <= {flashRdata[15:8], pHiNib, pLoNib};
        else
          fcReadDataReg <= flashRdata;
        fcReadFailReg <= pCorr || pUncorr;
      end
      else
        fcReadFailReg <= 1'b0;
      fetchErrResetReg <= pUncorrEv && fSrcFetch2Reg && fetchErrResetEnReg;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration, flags and fault addresses.
  // --------------------------------------------------------------------------
  always @*
  begin
    progCfgNext = cfgNext(progCfgReg, hwdata[7:0],
                          wrCommit && (wrSelReg == SEL_PCFG) && protWriteUnlock,
                          pUncorrEv, pCorrEv);
    dataCfgNext = cfgNext(dataCfgReg, hwdata[7:0],
                          wrCommit && (wrSelReg == SEL_DCFG) && protWriteUnlock,
                          dUncorrEv, dCorrEv);
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      progCfgReg <= `MECCF_CFG_RST;
      dataCfgReg <= `MECCF_CFG_RST;
      progFaultAddrReg <= `MECCF_FADDR_RST;
      dataFaultAddrReg <= `MECCF_FADDR_RST;
      fetchErrResetEnReg <= 1'b0;
    end
    else
    begin
      progCfgReg <= progCfgNext;
      dataCfgReg <= dataCfgNext;
      if (wrCommit && (wrSelReg == SEL_RCTL) && protWriteUnlock)
        fetchErrResetEnReg <= hwdata[`MECCF_B_RSTEN];
      if (pFetchErr)
        progFaultAddrReg <= fAddr2Reg;
      else if (wrCommit && (wrSelReg == SEL_PADH))
        progFaultAddrReg[15:8] <= hwdata[7:0];
      // The first faulting address survives until software clears both flags.
      if ((dCorrEv || dUncorrEv) &&
          !dataCfgReg[`MECCF_B_UF] && !dataCfgReg[`MECCF_B_CF])
        dataFaultAddrReg <= dAddr2Reg;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt requests.
  // --------------------------------------------------------------------------
  assign dataUncorrIrq = dataCfgReg[`MECCF_B_UF] && dataCfgReg[`MECCF_B_UIE];
  assign dataCorrIrq = dataCfgReg[`MECCF_B_CF] && dataCfgReg[`MECCF_B_CIE];
  assign progUncorrIrq = progCfgReg[`MECCF_B_UF] && progCfgReg[`MECCF_B_UIE];
  assign progCorrIrq = progCfgReg[`MECCF_B_CF] && progCfgReg[`MECCF_B_CIE];

endmodule

// File: test/meccf_top_sva.sv
`timescale 1ns/1ps
module meccf_top_sva
(
  input logic clk_sys,
  input logic rst_n,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic cpuDataRd,
  input logic cpuDataWr,
  input logic [15:0] cpuDataAddr,
  input logic [7:0] cpuDataWdata,
  input logic [7:0] cpuDataRdata,
  input logic cpuDataRvalid,
  input logic [10:0] sramAddr,
  input logic sramRd,
  input logic sramWr,
  input logic [12:0] sramWdata,
  input logic [12:0] sramRdata,
  input logic fetchReq,
  input logic [15:0] fetchAddr,
  input logic [7:0] fetchData,
  input logic fetchValid,
  input logic fcReadValid,
  input logic [15:0] flashAddr,
  input logic flashRd,
  input logic [15:0] flashRdata,
  input logic dataUncorrIrq,
  input logic progUncorrIrq,
  input logic fetchErrReset
);
  logic wrPh;
  wire cleanF;
  wire cleanD;

  function automatic logic [3:0] nenc(input logic [3:0] d);
    logic [2:0] c;
    c = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
    nenc = {^{c, d}, c};
  endfunction

  function automatic logic [4:0] henc(input logic [7:0] d);
    logic [3:0] p;
    p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
    p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
    p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
    p[3] = ^d[7:4];
    henc = {^{p, d}, p};
  endfunction

  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      wrPh <= 1'b0;
    else
      wrPh <= hsel && htrans[1] && hready && hwrite;

  assign cleanF = flashRdata[15:8] == {nenc(flashRdata[7:4]), nenc(flashRdata[3:0])};
  assign cleanD = sramRdata[12:8] == henc(sramRdata[7:0]);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_sramRead;
    sramRd && sramAddr == $past(cpuDataAddr[10:0]);
  endsequence
  sequence s_flashRead;
    flashRd && flashAddr == $past(fetchAddr);
  endsequence

  property p_dataRead;
    cpuDataRd && !cpuDataWr |=> s_sramRead ##2 cpuDataRvalid;
  endproperty
  a_dataRead: assert property (p_dataRead) else $error("data read path broken");
  property p_dataWrite;
    cpuDataWr |=> sramWr && sramAddr == $past(cpuDataAddr[10:0])
      && sramWdata[7:0] == $past(cpuDataWdata);
  endproperty
  a_dataWrite: assert property (p_dataWrite) else $error("data write path broken");
  property p_checkBits;
    sramWr |-> sramWdata[12:8] == henc(sramWdata[7:0]) || sramWdata[12:8] == 5'h00;
  endproperty
  a_checkBits: assert property (p_checkBits) else $error("bad check bits");
  property p_dataClean;
    cpuDataRvalid && $past(cleanD) |-> cpuDataRdata == $past(sramRdata[7:0]);
  endproperty
  a_dataClean: assert property (p_dataClean) else $error("clean data altered");
  property p_fetch;
    fetchReq |=> s_flashRead ##2 fetchValid;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch path broken");
  property p_fetchClean;
    fetchValid && $past(cleanF) |-> fetchData == $past(flashRdata[7:0]) && !fetchErrReset;
  endproperty
  a_fetchClean: assert property (p_fetchClean) else $error("clean fetch altered");
  property p_errReset;
    fetchErrReset |-> fetchValid && !$past(cleanF);
  endproperty
  a_errReset: assert property (p_errReset) else $error("reset without fetch error");
  property p_dataIrq;
    $rose(dataUncorrIrq) |-> cpuDataRvalid || $past(wrPh);
  endproperty
  a_dataIrq: assert property (p_dataIrq) else $error("data irq without cause");
  property p_progIrq;
    $rose(progUncorrIrq) |-> fetchValid || fcReadValid || $past(wrPh);
  endproperty
  a_progIrq: assert property (p_progIrq) else $error("program irq without cause");
endmodule

bind meccf_top meccf_top_sva i_meccf_top_sva (.*);

// File: test/meccf_mem_model.sv
`timescale 1ns/1ps
module meccf_mem_model
(
  input logic clk_sys,
  input logic [10:0] sramAddr,
  input logic sramRd,
  input logic sramWr,
  input logic [12:0] sramWdata,
  output logic [12:0] sramRdata,
  input logic [15:0] flashAddr,
  input logic flashRd,
  output logic [15:0] flashRdata,
  input logic [12:0] sramFlip,
  input logic [15:0] flashFlip
);
  logic [12:0] mem [0:2047];

  function automatic logic [3:0] nenc(input logic [3:0] d);
    logic [2:0] c;
    c = {d[1] ^ d[2] ^ d[3], d[0] ^ d[2] ^ d[3], d[0] ^ d[1] ^ d[3]};
    nenc = {^{c, d}, c};
  endfunction

  function automatic logic [15:0] flashWord(input logic [15:0] a);
    logic [7:0] d;
    d = a[7:0] ^ a[15:8] ^ 8'h5a;
    flashWord = {nenc(d[7:4]), nenc(d[3:0]), d};
  endfunction

  initial
  begin
    sramRdata = 13'h0000;
    flashRdata = 16'h0000;
  end

  // Idle read data toggles so that a late sample shows up.
  always @(posedge clk_sys)
  begin
    if (sramWr)
      mem[sramAddr] <= sramWdata;
    sramRdata <= sramRd ? mem[sramAddr] ^ sramFlip : ~sramRdata;
    flashRdata <= flashRd ? flashWord(flashAddr) ^ flashFlip : ~flashRdata;
  end
endmodule

// File: test/tb_top.sv
`timescale 1ns/1ps
`include "meccf_regs.vh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, protWriteUnlock, cpuDataRd, cpuDataWr, fetchReq, fcReadReq;
  logic sawReset, sawFail;
  logic [31:0] haddr, hwdata, r, lfsr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] cpuDataAddr, fetchAddr, fcReadAddr, flashFlip;
  logic [7:0] cpuDataWdata;
  logic [7:0] ram [0:31];
  logic [12:0] sramFlip;
  wire hreadyout, hresp, cpuDataRvalid, sramRd, sramWr, fetchValid, fcReadReady, fcReadValid;
  wire fcReadFail, flashRd, dataUncorrIrq, dataCorrIrq, progUncorrIrq, progCorrIrq;
  wire fetchErrReset;
  wire [31:0] hrdata;
  wire [7:0] cpuDataRdata, fetchData;
  wire [10:0] sramAddr;
  wire [12:0] sramWdata, sramRdata;
  wire [15:0] fcReadData, flashAddr, flashRdata;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;

  meccf_top i_meccf_top (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .protWriteUnlock, .cpuDataRd, .cpuDataWr,
    .cpuDataAddr, .cpuDataWdata, .cpuDataRdata, .cpuDataRvalid, .sramAddr, .sramRd, .sramWr,
    .sramWdata, .sramRdata, .fetchReq, .fetchAddr, .fetchData, .fetchValid, .fcReadReq,
    .fcReadAddr, .fcReadReady, .fcReadData, .fcReadValid, .fcReadFail, .flashAddr, .flashRd,
    .flashRdata, .dataUncorrIrq, .dataCorrIrq, .progUncorrIrq, .progCorrIrq, .fetchErrReset);
  meccf_mem_model i_meccf_mem_model (.clk_sys, .sramAddr, .sramRd, .sramWr, .sramWdata,
    .sramRdata, .flashAddr, .flashRd, .flashRdata, .sramFlip, .flashFlip);

  always #12.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test;
    end
  end

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] romByte(input logic [15:0] x);
    romByte = x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction

  task automatic chk(input string name, input logic [31:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic waitOn(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (n < 16 && !(k == 0 ? hreadyout === 1'b1 : k == 1 ? cpuDataRvalid === 1'b1 :
      (fetchValid | fcReadValid) === 1'b1));
    if (n == 16)
      chk("handshake", 1, 0);
  endtask

  task automatic ahb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {14'h0000, idx, 2'h0};
    waitOn(0);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    waitOn(0);
    r = hrdata;
    @(posedge clk_sys);
  endtask

  task automatic regChk(input logic [15:0] idx, input logic [7:0] e);
    ahb(1'b0, idx, 8'h00);
    chk("register", e, r);
    chk("hresp", 0, hresp);
  endtask

  task automatic dWrite(input logic [15:0] ad, input logic [7:0] d);
    cpuDataWr <= 1'b1;
    cpuDataAddr <= ad;
    cpuDataWdata <= d;
    @(posedge clk_sys);
    cpuDataWr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic dRead(input logic [15:0] ad, input logic [12:0] fl, input logic [7:0] e);
    sramFlip <= fl;
    cpuDataRd <= 1'b1;
    cpuDataAddr <= ad;
    @(posedge clk_sys);
    cpuDataRd <= 1'b0;
    waitOn(1);
    chk("data", e, cpuDataRdata);
  endtask

  task automatic fAcc(input logic fc, input logic [15:0] ad, fl, e);
    flashFlip <= fl;
    fetchReq <= !fc;
    fcReadReq <= fc;
    fetchAddr <= ad;
    fcReadAddr <= ad;
    @(posedge clk_sys);
    fetchReq <= 1'b0;
    fcReadReq <= 1'b0;
    waitOn(2);
    sawReset = fetchErrReset;
    sawFail = fcReadFail;
    chk("flash", e, fc ? fcReadData : {8'h00, fetchData});
  endtask

  initial
  begin
    {hsel, hwrite, protWriteUnlock, cpuDataRd, cpuDataWr, fetchReq, fcReadReq, haddr, hwdata,
      htrans, cpuDataAddr, fetchAddr, fcReadAddr, flashFlip, cpuDataWdata, sramFlip} = '0;
    hsize = 3'h2;
    lfsr = 32'h0000_a365;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    regChk(`MECCF_IDX_PCFG, 8'h80);
    regChk(`MECCF_IDX_PADH, 8'h00);
    regChk(`MECCF_IDX_DCFG, 8'h80);
    regChk(`MECCF_IDX_DADH, 8'h80);
    regChk(`MECCF_IDX_RCTL, 8'h00);
    ahb(1'b1, 16'ha031, 8'hff);
    regChk(16'ha031, 8'h00);
    for (int i = 0; i < 32; i++)
    begin
      lfsr = nextRand(lfsr);
      ram[i] = lfsr[7:0];
      dWrite(16'(i), ram[i]);
    end
    for (int i = 0; i < 32; i++)
      dRead(16'(i), 13'h0000, ram[i]);
    for (int i = 5; i < 13; i++)
    begin
      lfsr = nextRand(lfsr);
      dRead(16'(i), 13'h0001 << (lfsr[7:0] % 13), ram[i]);
    end
    regChk(`MECCF_IDX_DCFG, 8'h81);
    regChk(`MECCF_IDX_DADL, 8'h05);
    ahb(1'b1, `MECCF_IDX_DCFG, 8'hb1);
    regChk(`MECCF_IDX_DCFG, 8'h81);
    protWriteUnlock <= 1'b1;
    ahb(1'b1, `MECCF_IDX_DCFG, 8'hb1);
    chk("dataCorrIrq", 1, dataCorrIrq);
    ahb(1'b1, `MECCF_IDX_DCFG, 8'hb0);
    chk("dataCorrIrq", 0, dataCorrIrq);
    dWrite(16'h0014, 8'h3c);
    dRead(16'h0014, 13'h0204, 8'h3c ^ 8'h04);
    chk("dataUncorrIrq", 1, dataUncorrIrq);
    chk("dataCorrIrq", 0, dataCorrIrq);
    dWrite(16'h0015, 8'h3c);
    dRead(16'h0015, 13'h0030, 8'h3c ^ 8'h30);
    regChk(`MECCF_IDX_DADL, 8'h14);
    regChk(`MECCF_IDX_DCFG, 8'hb2);
    ahb(1'b1, `MECCF_IDX_DCFG, 8'h00);
    dWrite(16'h0003, 8'h96);
    dRead(16'h0003, 13'h0001, 8'h97);
    regChk(`MECCF_IDX_DCFG, 8'h00);
    ahb(1'b1, `MECCF_IDX_DCFG, 8'h80);
    for (int i = 0; i < 16; i++)
    begin
      lfsr = nextRand(lfsr);
      fAcc(1'b0, lfsr[15:0], 16'h0000, romByte(lfsr[15:0]));
    end
    regChk(`MECCF_IDX_PCFG, 8'h80);
    fAcc(1'b0, 16'hc3a5, 16'h0011, romByte(16'hc3a5));
    fAcc(1'b0, 16'h4b1e, 16'h2200, romByte(16'h4b1e));
    regChk(`MECCF_IDX_PCFG, 8'h81);
    regChk(`MECCF_IDX_PADL, 8'h1e);
    regChk(`MECCF_IDX_PADH, 8'h0b);
    fAcc(1'b0, 16'h8123, 16'h0003, romByte(16'h8123) ^ 8'h03);
    chk("fetchErrReset", 0, sawReset);
    chk("progUncorrIrq", 0, progUncorrIrq);
    regChk(`MECCF_IDX_PCFG, 8'h83);
    regChk(`MECCF_IDX_PADL, 8'h23);
    ahb(1'b1, `MECCF_IDX_PCFG, 8'ha3);
    chk("progUncorrIrq", 1, progUncorrIrq);
    chk("progCorrIrq", 0, progCorrIrq);
    ahb(1'b1, `MECCF_IDX_RCTL, 8'h01);
    fAcc(1'b0, 16'h0042, 16'h0030, romByte(16'h0042) ^ 8'h30);
    chk("fetchErrReset", 1, sawReset);
    fAcc(1'b1, 16'h1234, 16'h0004, i_meccf_mem_model.flashWord(16'h1234));
    chk("fcReadFail", 1, sawFail);
    ahb(1'b1, `MECCF_IDX_PCFG, 8'h00);
    fAcc(1'b1, 16'h1234, 16'h0004, i_meccf_mem_model.flashWord(16'h1234) ^ 16'h0004);
    end_of_test;
  end
endmodule
